//--- pkg/jtl_pkg.sv
// Shared constants, tables and types for the serial transmit transport and link block
package jtl_pkg;
    localparam int         OCT_W       = 8;
    localparam int         CHR_W       = 10;
    localparam int         BLK_W       = 64;
    localparam int         SH_W        = 2;
    localparam int         LINE_W      = 66;
    localparam int         PAR_W       = 26;
    localparam int         MIX8_W      = 15;
    localparam int         MIX64_W     = 58;
    localparam int         MIX8_TAP_A  = 13;
    localparam int         MIX8_TAP_B  = 14;
    localparam int         MIX64_TAP_A = 38;
    localparam int         MIX64_TAP_B = 57;
    localparam int         MODE_SEL_W  = 4;
    localparam logic [2:0] BLK_LAST    = 3'h7;
    localparam logic [4:0] MB_LAST     = 5'h1f;
    localparam logic [4:0] PILOT_POS   = 5'h1b;
    localparam logic [4:0] PILOT_BITS  = 5'h01;
    localparam logic [1:0] ILAS_LAST   = 2'h3;
    localparam logic [7:0] K_COMMA     = 8'hbc;
    localparam logic [7:0] K_MF_START  = 8'h1c;
    localparam logic [7:0] K_MF_ALIGN  = 8'h7c;
    localparam logic [7:0] FILL_OCTET  = 8'h00;
    localparam logic [SH_W-1:0]  SH_BIT0  = 2'h1;
    localparam logic [SH_W-1:0]  SH_BIT1  = 2'h2;
    // Parity generator over the multiblock payload
    localparam logic [PAR_W-1:0] FEC_POLY = 26'h20004c7;
    localparam logic [5:0] K28_6B      = 6'h0f;
    localparam logic [5:0] D7_6B       = 6'h38;
    localparam logic [3:0] X3_4B       = 4'hc;
    localparam logic [3:0] ALT7_4B     = 4'h7;
    // 5b/6b and 3b/4b codes for negative running disparity, bit a first
    localparam logic [5:0] ENC6 [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] ENC4D [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    localparam logic [3:0] ENC4K [8] = '{4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};

    typedef struct packed {
        logic       enc64;
        logic [4:0] f_oct;
        logic [8:0] k_frm;
    } jtl_mode_t;

    typedef struct packed {
        logic              is_block;
        logic [LINE_W-1:0] bits;
    } jtl_lane_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CGS, ST_WAIT_LMFC, ST_ILAS, ST_DATA8, ST_DATA64
    } jtl_state_t;

    // Only the two supported line codings exist in the mode table
    function automatic jtl_mode_t jtl_mode_lookup(input logic [MODE_SEL_W-1:0] sel);
        case (sel)
            4'h1:    return '{enc64: 1'b0, f_oct: 5'h04, k_frm: 9'h010};
            4'h2:    return '{enc64: 1'b1, f_oct: 5'h08, k_frm: 9'h020};
            4'h3:    return '{enc64: 1'b1, f_oct: 5'h04, k_frm: 9'h040};
            default: return '{enc64: 1'b0, f_oct: 5'h02, k_frm: 9'h020};
        endcase
    endfunction
endpackage

//--- src/jtl_tx.sv
// Sample FIFO and serial transmit transport plus 8b/10b and 64b/66b link logic
`timescale 1ns/1ps

module jtl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             rdy_q, rdy_d;
    logic             push, pop;

    always_comb begin
        push  = i_valid && rdy_q;
        pop   = (cnt_q != '0) && i_ready;
        wr_d  = wr_q;
        rd_d  = rd_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        // Registered ready: full is judged on the next count, so no overrun
        rdy_d = (cnt_d != FULL);
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    assign o_ready = rdy_q;
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rd_q];
endmodule

module jtl_tx
    import jtl_pkg::*;
#(
    parameter int SAMPLE_W   = 16,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic [SAMPLE_W-1:0]   i_sample,
    input  wire logic                  i_sample_valid,
    output logic                       o_sample_ready,
    input  wire logic                  i_link_enable,
    input  wire logic [MODE_SEL_W-1:0] i_transport_mode_select,
    input  wire logic                  i_scramble_enable,
    input  wire logic                  i_fec_enable,
    input  wire logic                  i_sync_n,
    input  wire logic                  i_sysref,
    output jtl_lane_t                  o_lane,
    output logic                       o_lane_valid,
    output logic                       o_link_up,
    output logic                       o_mf_edge
);
    localparam int SPO   = SAMPLE_W / OCT_W;
    localparam int SUB_W = (SPO > 1) ? $clog2(SPO) : 1;
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SPO - 1);

    function automatic logic [CHR_W:0] enc_8b10b(input logic [7:0] d, input logic k,
                                                 input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic       rd_m;
        logic       alt;
        c6 = k ? K28_6B : ENC6[d[4:0]];
        if (rd && (($countones(c6) != 3) || (c6 == D7_6B))) begin
            c6 = ~c6;
        end
        rd_m = ($countones(c6) == 3) ? rd : ~rd;
        alt  = k || (!rd_m && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
                 || (rd_m && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e));
        c4 = k ? ENC4K[d[7:5]] : ENC4D[d[7:5]];
        if (d[7:5] == 3'h7 && alt) begin
            c4 = ALT7_4B;
        end
        if (rd_m && (($countones(c4) != 2) || k || (c4 == X3_4B))) begin
            c4 = ~c4;
        end
        return {(($countones(c4) == 2) ? rd_m : ~rd_m), c6, c4};
    endfunction

    // Self-synchronous: state is the last scrambled bits, so no seed is sent
    function automatic logic [MIX8_W+OCT_W-1:0] mix8(input logic [7:0] d,
                                                     input logic [MIX8_W-1:0] s);
        logic [MIX8_W-1:0] st;
        logic [7:0]        o;
        st = s;
        for (int i = OCT_W - 1; i >= 0; i--) begin
            o[i] = d[i] ^ st[MIX8_TAP_A] ^ st[MIX8_TAP_B];
            st   = {st[MIX8_W-2:0], o[i]};
        end
        return {st, o};
    endfunction

    function automatic logic [MIX64_W+BLK_W-1:0] mix64(input logic [BLK_W-1:0] d,
                                                       input logic [MIX64_W-1:0] s);
        logic [MIX64_W-1:0] st;
        logic [BLK_W-1:0]   o;
        st = s;
        for (int i = BLK_W - 1; i >= 0; i--) begin
            o[i] = d[i] ^ st[MIX64_TAP_A] ^ st[MIX64_TAP_B];
            st   = {st[MIX64_W-2:0], o[i]};
        end
        return {st, o};
    endfunction

    function automatic logic [PAR_W-1:0] fec_fold(input logic [PAR_W-1:0] acc,
                                                  input logic [BLK_W-1:0] d);
        logic [PAR_W-1:0] a;
        logic             fb;
        a = acc;
        for (int i = BLK_W - 1; i >= 0; i--) begin
            fb = a[PAR_W-1] ^ d[i];
            a  = {a[PAR_W-2:0], 1'b0} ^ (fb ? FEC_POLY : '0);
        end
        return a;
    endfunction

    jtl_state_t         state_q, state_d;
    jtl_mode_t          mode_q, mode_d;
    logic               mix_en_q, mix_en_d, fec_q, fec_d;
    logic               sync_q, sysref_q, rd_q, rd_d;
    logic [4:0]         oct_q, oct_d, blk_q, blk_d;
    logic [8:0]         frm_q, frm_d;
    logic [2:0]         bo_q, bo_d;
    logic [1:0]         mf_q, mf_d;
    logic [SUB_W-1:0]   sub_q, sub_d;
    logic [MIX8_W-1:0]  m8_q, m8_d;
    logic [MIX64_W-1:0] m64_q, m64_d;
    logic [BLK_W-1:0]   acc_q, acc_d;
    logic [PAR_W-1:0]   pacc_q, pacc_d, phold_q, phold_d;
    jtl_lane_t          lane_q, lane_d;
    logic               lv_q, lv_d, up_q, up_d, edge_q, edge_d;

    logic [SAMPLE_W-1:0]        f_data;
    logic                       f_valid, f_pop, take;
    logic                       frame_end, mf_end, mb_end, sysref_rise, hb;
    logic [7:0]                 octet, ch;
    logic                       is_k, emit8;
    logic [CHR_W:0]             code;
    logic [MIX8_W+OCT_W-1:0]    m8_res;
    logic [MIX64_W+BLK_W-1:0]   m64_res;
    logic [PAR_W-1:0]           fold;

    jtl_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_data     (i_sample),
        .i_valid    (i_sample_valid),
        .o_ready    (o_sample_ready),
        .o_data     (f_data),
        .o_valid    (f_valid),
        .i_ready    (f_pop)
    );

    always_comb begin
        state_d  = state_q;
        mode_d   = mode_q;
        mix_en_d = mix_en_q;
        fec_d    = fec_q;
        if (!i_link_enable) begin
            mode_d   = jtl_mode_lookup(i_transport_mode_select);
            mix_en_d = i_scramble_enable;
            fec_d    = i_fec_enable;
        end
        sysref_rise = i_sysref && !sysref_q;
        frame_end   = (oct_q == mode_q.f_oct - 5'h01);
        mf_end      = frame_end && (frm_q == mode_q.k_frm - 9'h001);
        mb_end      = (bo_q == BLK_LAST) && (blk_q == MB_LAST);
        // One counter set serves the single lane of the link
        oct_d = frame_end ? '0 : oct_q + 5'h01;
        frm_d = mf_end ? '0 : (frame_end ? frm_q + 9'h001 : frm_q);
        bo_d  = bo_q + 3'h1;
        blk_d = (bo_q == BLK_LAST) ? blk_q + 5'h01 : blk_q;
        if (!i_link_enable || sysref_rise) begin
            oct_d = '0;
            frm_d = '0;
            bo_d  = '0;
            blk_d = '0;
        end

        // Transport: samples leave the FIFO as octets, high octet first
        take   = (state_q == ST_DATA8) || (state_q == ST_DATA64);
        octet  = f_valid ? f_data[SAMPLE_W-1-OCT_W*int'(sub_q) -: OCT_W] : FILL_OCTET;
        f_pop  = take && f_valid && (sub_q == SUB_LAST);
        sub_d  = (take && f_valid) ? ((sub_q == SUB_LAST) ? '0 : sub_q + 1'b1) : sub_q;

        // 8b/10b character path
        ch     = K_COMMA;
        is_k   = 1'b1;
        emit8  = (state_q == ST_CGS) || (state_q == ST_WAIT_LMFC) ||
                 (state_q == ST_ILAS) || (state_q == ST_DATA8);
        m8_res = mix8(octet, m8_q);
        m8_d   = m8_q;
        mf_d   = mf_q;
        if (state_q == ST_ILAS) begin
            // Alignment sequence stays plain so the receiver can find boundaries
            is_k = (oct_q == '0 && frm_q == '0) || mf_end;
            ch   = (oct_q == '0 && frm_q == '0) ? K_MF_START :
                   (mf_end ? K_MF_ALIGN : 8'(oct_q));
            mf_d = mf_end ? mf_q + 2'h1 : mf_q;
        end else if (state_q == ST_DATA8) begin
            is_k = 1'b0;
            ch   = mix_en_q ? m8_res[OCT_W-1:0] : octet;
            m8_d = mix_en_q ? m8_res[MIX8_W+OCT_W-1:OCT_W] : m8_q;
        end
        code = enc_8b10b(ch, is_k, rd_q);
        rd_d = emit8 ? code[CHR_W] : rd_q;

        // 64b/66b block path, scrambling unconditional here
        acc_d   = {acc_q[BLK_W-OCT_W-1:0], octet};
        m64_res = mix64(acc_d, m64_q);
        fold    = fec_fold(pacc_q, m64_res[BLK_W-1:0]);
        m64_d   = m64_q;
        pacc_d  = pacc_q;
        phold_d = phold_q;
        // Header stream holds only parity and pilot; no command or CRC bits
        // Parity is one bit shorter than the 27 header slots before the pilot; the spare slot sends zero
        if (blk_q < 5'(PAR_W)) begin
            hb = fec_q && phold_q[PAR_W-1-int'(blk_q)];
        end else if (blk_q < PILOT_POS) begin
            hb = 1'b0;
        end else begin
            hb = PILOT_BITS[int'(MB_LAST)-int'(blk_q)];
        end
        lane_d = '{is_block: 1'b0, bits: LINE_W'(code[CHR_W-1:0])};
        lv_d   = emit8;
        if (state_q == ST_DATA64) begin
            lv_d = (bo_q == BLK_LAST);
            lane_d = '{is_block: 1'b1, bits: {(hb ? SH_BIT1 : SH_BIT0), m64_res[BLK_W-1:0]}};
            if (bo_q == BLK_LAST) begin
                m64_d  = m64_res[MIX64_W+BLK_W-1:BLK_W];
                pacc_d = mb_end ? '0 : fold;
                if (mb_end) begin
                    phold_d = fec_q ? fold : '0;
                end
            end
        end

        case (state_q)
            ST_IDLE:      state_d = mode_q.enc64 ? ST_DATA64 : ST_CGS;
            ST_CGS:       if (i_sync_n && !sync_q) state_d = ST_WAIT_LMFC;
            ST_WAIT_LMFC: if (mf_end) state_d = ST_ILAS;
            ST_ILAS:      if (mf_end && mf_q == ILAS_LAST) state_d = ST_DATA8;
            ST_DATA8:     state_d = ST_DATA8;
            ST_DATA64:    state_d = ST_DATA64;
            default:      state_d = ST_IDLE;
        endcase
        if ((state_q == ST_WAIT_LMFC || state_q == ST_ILAS || state_q == ST_DATA8)
            && !i_sync_n) begin
            state_d = ST_CGS;
        end
        if (state_d != ST_ILAS) begin
            mf_d = '0;
        end
        if (!i_link_enable) begin
            state_d = ST_IDLE;
            lv_d    = 1'b0;
        end
        up_d   = (state_d == ST_DATA8) || (state_d == ST_DATA64);
        edge_d = i_link_enable && (mode_q.enc64 ? mb_end : mf_end);
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q  <= ST_IDLE;
            mode_q   <= '0;
            mix_en_q <= 1'b0;
            fec_q    <= 1'b0;
            sync_q   <= 1'b0;
            sysref_q <= 1'b0;
            rd_q     <= 1'b0;
            oct_q    <= '0;
            frm_q    <= '0;
            bo_q     <= '0;
            blk_q    <= '0;
            mf_q     <= '0;
            sub_q    <= '0;
            m8_q     <= '0;
            m64_q    <= '0;
            acc_q    <= '0;
            pacc_q   <= '0;
            phold_q  <= '0;
            lane_q   <= '0;
            lv_q     <= 1'b0;
            up_q     <= 1'b0;
            edge_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            mode_q   <= mode_d;
            mix_en_q <= mix_en_d;
            fec_q    <= fec_d;
            sync_q   <= i_sync_n;
            sysref_q <= i_sysref;
            rd_q     <= rd_d;
            oct_q    <= oct_d;
            frm_q    <= frm_d;
            bo_q     <= bo_d;
            blk_q    <= blk_d;
            mf_q     <= mf_d;
            sub_q    <= sub_d;
            m8_q     <= m8_d;
            m64_q    <= m64_d;
            acc_q    <= acc_d;
            pacc_q   <= pacc_d;
            phold_q  <= phold_d;
            lane_q   <= lane_d;
            lv_q     <= lv_d;
            up_q     <= up_d;
            edge_q   <= edge_d;
        end
    end

    assign o_lane       = lane_q;
    assign o_lane_valid = lv_q;
    assign o_link_up    = up_q;
    assign o_mf_edge    = edge_q;
endmodule

//--- tb/jtl_rx_model.sv
// Receiver model that drives the sync handshake from the comma stream
`timescale 1ns/1ps
module jtl_rx_model
    import jtl_pkg::*;
(
    input  wire logic      i_core_clk,
    input  wire logic      i_rst,
    input  wire jtl_lane_t i_lane,
    input  wire logic      i_lane_valid,
    input  wire logic      i_want_link,
    input  wire logic      i_slow,
    output logic           o_sync_n
);
    logic [4:0] commas_q;
    logic       comma;
    assign comma = i_lane_valid && !i_lane.is_block
        && (i_lane.bits[9:0] == 10'h0fa || i_lane.bits[9:0] == 10'h305);
    // Slow mode asks for many more commas before letting go
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            commas_q <= 5'h00;
            o_sync_n <= 1'b0;
        end else if (!i_want_link) begin
            commas_q <= 5'h00;
            o_sync_n <= 1'b0;
        end else if (!o_sync_n) begin
            commas_q <= comma ? commas_q + 5'h01 : 5'h00;
            if (comma && commas_q == (i_slow ? 5'h13 : 5'h03)) o_sync_n <= 1'b1;
        end
    end
endmodule

//--- tb/jtl_tx_sva.sv
// Port level checks for the serial transmit transport and link block
`timescale 1ns/1ps
module jtl_tx_sva
    import jtl_pkg::*;
#(
    parameter int SAMPLE_W   = 16,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_rst,
    input wire logic [SAMPLE_W-1:0]   i_sample,
    input wire logic                  i_sample_valid,
    input wire logic                  o_sample_ready,
    input wire logic                  i_link_enable,
    input wire logic [MODE_SEL_W-1:0] i_transport_mode_select,
    input wire logic                  i_scramble_enable,
    input wire logic                  i_fec_enable,
    input wire logic                  i_sync_n,
    input wire logic                  i_sysref,
    input wire jtl_lane_t             o_lane,
    input wire logic                  o_lane_valid,
    input wire logic                  o_link_up,
    input wire logic                  o_mf_edge
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic comma;
    assign comma = o_lane.bits[9:0] == 10'h0fa || o_lane.bits[9:0] == 10'h305;

    chk_reset_idle: assert property (disable iff (1'b0) i_rst |-> o_lane == '0
        && !o_lane_valid && !o_link_up && !o_mf_edge && !o_sample_ready)
        else $error("outputs not idle in reset");
    chk_ready_wake: assert property ($fell(i_rst) |-> ##2 o_sample_ready)
        else $error("sample ready late after reset");
    chk_header_legal: assert property (o_lane_valid && o_lane.is_block |->
        o_lane.bits[65:64] == SH_BIT0 || o_lane.bits[65:64] == SH_BIT1)
        else $error("illegal sync header");
    chk_block_period: assert property (disable iff (i_rst || !i_link_enable)
        o_lane_valid && o_lane.is_block |=> !o_lane_valid [*7] ##1 o_lane_valid)
        else $error("block spacing wrong");
    chk_comma_hold: assert property (!i_sync_n && i_link_enable && o_lane_valid
        && !o_lane.is_block |-> ##2 comma)
        else $error("no comma while sync low");
    chk_disp_flip: assert property (o_lane_valid && !o_lane.is_block && comma |=>
        !o_lane_valid || o_lane.bits[9:0] != $past(o_lane.bits[9:0]))
        else $error("running disparity not flipped");
    chk_ilas_first: assert property (o_lane_valid && !o_lane.is_block && comma |=>
        !o_lane_valid || comma || o_lane.bits[9:0] == 10'h0f4 || o_lane.bits[9:0] == 10'h30b)
        else $error("commas not followed by start marker");
    chk_enable_off: assert property (!i_link_enable ##1 !i_link_enable |=>
        !o_lane_valid && !o_link_up)
        else $error("link active while disabled");
    chk_sync_ignored: assert property (o_link_up && o_lane.is_block && i_link_enable
        |=> o_link_up)
        else $error("block link dropped");
endmodule

bind jtl_tx jtl_tx_sva #(.SAMPLE_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sample(i_sample),
    .i_sample_valid(i_sample_valid), .o_sample_ready(o_sample_ready),
    .i_link_enable(i_link_enable), .i_transport_mode_select(i_transport_mode_select),
    .i_scramble_enable(i_scramble_enable), .i_fec_enable(i_fec_enable),
    .i_sync_n(i_sync_n), .i_sysref(i_sysref), .o_lane(o_lane),
    .o_lane_valid(o_lane_valid), .o_link_up(o_link_up), .o_mf_edge(o_mf_edge));

//--- tb/jtl_tx_tb.sv
// Self-checking bench for the serial transmit transport and link block
`timescale 1ns/1ps
module jtl_tx_tb
    import jtl_pkg::*;
;
    typedef struct packed {
        logic [3:0] sel;
        logic       blk;
    } jtl_row_t;
    localparam jtl_row_t ROWS [5] = '{'{4'h0, 1'b0}, '{4'h1, 1'b0}, '{4'h2, 1'b1},
                                      '{4'h3, 1'b1}, '{4'hf, 1'b0}};
    logic        clk    = 1'b0;
    logic        rst    = 1'b0;
    logic [15:0] sample = 16'h0000;
    logic        svalid = 1'b0;
    logic        en     = 1'b0;
    logic [3:0]  sel    = 4'h0;
    logic        scramble_enable    = 1'b0;
    logic        fec    = 1'b0;
    logic        sysref = 1'b0;
    logic        want   = 1'b0;
    logic        slow   = 1'b0;
    logic        sready, sync_n, lvalid, up, mfe, odd;
    jtl_lane_t   lane;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          acc        = 0;
    int          t0, t1, k1, n, i;
    logic [57:0] ds     = '0;
    logic [63:0] plain;

    jtl_tx #(.SAMPLE_W(16), .FIFO_DEPTH(8)) uut (
        .i_core_clk(clk), .i_rst(rst), .i_sample(sample), .i_sample_valid(svalid),
        .o_sample_ready(sready), .i_link_enable(en), .i_transport_mode_select(sel),
        .i_scramble_enable(scramble_enable), .i_fec_enable(fec), .i_sync_n(sync_n), .i_sysref(sysref),
        .o_lane(lane), .o_lane_valid(lvalid), .o_link_up(up), .o_mf_edge(mfe));
    jtl_rx_model u_rx (
        .i_core_clk(clk), .i_rst(rst), .i_lane(lane), .i_lane_valid(lvalid),
        .i_want_link(want), .i_slow(slow), .o_sync_n(sync_n));

    always #5 clk = ~clk;

    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic chkc(input logic [9:0] got, input logic [9:0] neg, input logic [9:0] pos,
                        input string what);
        chk(got === neg || got === pos, 1'b1, what);
    endtask
    // Skips the first cycles so a pulse already in flight is not counted
    task automatic sysref_gap(output int gap);
        @(posedge clk);
        sysref <= 1'b1;
        @(posedge clk);
        sysref <= 1'b0;
        cyc(3);
        gap = 3;
        while (mfe !== 1'b1 && gap < 200) begin
            @(posedge clk);
            gap++;
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (svalid && sready) acc <= acc + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end

    initial begin
        // Real edge at time zero so every flop but the FIFO storage starts from reset, not unknown
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        @(negedge clk);
        chk(lvalid | up | mfe | sready | (lane != '0), 1'b0, "not idle after reset");
        @(posedge clk);
        sample <= 16'hffff;
        svalid <= 1'b1;
        cyc(14);
        @(negedge clk);
        chk(sready, 1'b0, "ready while fifo full");
        chk(acc == 8, 1'b1, "fifo depth");
        foreach (ROWS[r]) begin
            @(posedge clk);
            en <= 1'b0;
            sel <= ROWS[r].sel;
            cyc(3);
            en <= 1'b1;
            cyc(40);
            @(negedge clk);
            chk(lane.is_block, ROWS[r].blk, "coding of mode");
            chk(up, ROWS[r].blk, "link state of mode");
            if (!ROWS[r].blk) chkc(lane.bits[9:0], 10'h0fa, 10'h305, "no comma");
        end
        @(posedge clk);
        sel <= 4'h2;
        cyc(20);
        @(negedge clk);
        chk(lane.is_block, 1'b0, "mode changed while enabled");
        sysref_gap(t0);
        cyc(7);
        sysref_gap(t1);
        chk(t0 == t1 && t0 < 70, 1'b1, "multiframe phase after sysref");
        @(posedge clk);
        en <= 1'b0;
        sel <= 4'h0;
        scramble_enable <= 1'b1;
        cyc(3);
        en <= 1'b1;
        want <= 1'b1;
        slow <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 2000 && (lvalid !== 1'b1 || lane.bits[9:0] === 10'h0fa
                                || lane.bits[9:0] === 10'h305));
        chkc(lane.bits[9:0], 10'h0f4, 10'h30b, "alignment start");
        for (i = 1; i < 256; i++) begin
            @(negedge clk);
            if (i == 2) chkc(lane.bits[9:0], 10'h274, 10'h18b, "alignment octet");
            if (i == 63) chkc(lane.bits[9:0], 10'h0f3, 10'h30c, "multiframe end");
            if (i == 64) chkc(lane.bits[9:0], 10'h0f4, 10'h30b, "multiframe start");
            if (i >= 254) chk(up, i == 255, "link up timing");
        end
        @(posedge clk);
        want <= 1'b0;
        cyc(5);
        @(negedge clk);
        chkc(lane.bits[9:0], 10'h0fa, 10'h305, "comma after sync loss");
        chk(up, 1'b0, "link up after sync loss");
        @(posedge clk);
        en <= 1'b0;
        sel <= 4'h2;
        scramble_enable <= 1'b0;
        cyc(3);
        en <= 1'b1;
        k1 = -1;
        n = 0;
        odd = 1'b0;
        // Scrambler off here; block coding must scramble anyway
        for (i = 0; i < 800; i++) begin
            @(negedge clk);
            if (lvalid === 1'b1) begin
                n++;
                // Self-synchronising descrambler, no seed shared with the sender
                for (int b = 63; b >= 0; b--) begin
                    plain[b] = lane.bits[b] ^ ds[38] ^ ds[57];
                    ds       = {ds[56:0], lane.bits[b]};
                end
                if (n > 10) chk(plain === {64{1'b1}}, 1'b1, "descrambled payload");
                if (n > 10 && lane.bits[63:0] !== {64{1'b1}}) odd = 1'b1;
                if (lane.bits[65:64] === SH_BIT1) begin
                    if (k1 >= 0) chk(n - k1 == 32, 1'b1, "multiblock length");
                    k1 = n;
                end
            end
        end
        chk(k1 > 0, 1'b1, "no pilot header");
        chk(odd, 1'b1, "block payload unscrambled");
        @(posedge clk);
        en  <= 1'b0;
        fec <= 1'b1;
        cyc(3);
        en  <= 1'b1;
        k1 = 0;
        // Parity of earlier multiblocks adds ones beyond the single pilot one
        for (i = 0; i < 800; i++) begin
            @(negedge clk);
            if (lvalid === 1'b1 && lane.bits[65:64] === SH_BIT1) k1++;
        end
        chk(k1 > 4, 1'b1, "no parity in headers");
        summarize();
    end
endmodule
